// *** gps_link_defines.vh ***
`ifndef GPS_LINK_DEFINES_VH
`define GPS_LINK_DEFINES_VH

// byte offsets of the pointer, debug and error registers
`define RX_PTR_OFFSET 16'h3200
`define TX_PTR_OFFSET 16'h3204
`define DEBUG_OFFSET 16'h3208
`define ERR_OFFSET 16'h320C

// data windows, selected by address bits 15..11
`define RX_WIN_BASE 16'h4000
`define RX_WIN_LAST 16'h47FF
`define TX_WIN_BASE 16'h4800
`define TX_WIN_LAST 16'h4FFF
`define WIN_SEL_MSB 15
`define WIN_SEL_LSB 11
`define RX_WIN_SEL 5'h08
`define TX_WIN_SEL 5'h09
`define WORD_IDX_LSB 2

// pointer register layout: head in the upper half, tail in the lower
`define HEAD_LSB 16
`define TAIL_LSB 0

// error register layout
`define PPS_OK_LSB 24
`define PARITY_ERR_LSB 16
`define SHORT_START_LSB 8
`define ERR_CNT_W 8

// debug control width and reset values
`define DEBUG_W 8
`define DEBUG_RESET 8'h00
`define PTR_RESET 9'h000
`define CNT_RESET 8'h00

`endif

// *** event_counter.v ***
`timescale 1ns/1ps
`include "gps_link_defines.vh"

module event_counter #(
	parameter W = `ERR_CNT_W
)(
	input wire sys_clk,
	input wire reset,
	input wire clear,
	input wire event_pulse,
	output wire [W-1:0] count
);

reg [W-1:0] count_r;
reg [W-1:0] count_nxt;
wire at_max;

assign at_max = &count_r;
assign count = count_r;

// saturating count; an event during a clear survives as a count of one
always @*
begin
	count_nxt = count_r;
	if (clear)
	begin
		count_nxt = {W{1'b0}};
		if (event_pulse)
			count_nxt = {{(W-1){1'b0}}, 1'b1};
	end
	else if (event_pulse && !at_max)
		count_nxt = count_r + 1'b1;
end

// stops at all ones so software never sees a wrapped, misleading total
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
		count_r <= {W{1'b0}};
	else
		count_r <= count_nxt;
end

endmodule

// *** gps_link_buffer_regs.v ***
`timescale 1ns/1ps
`include "gps_link_defines.vh"

// Function
// - receive pointer register holds head and tail
// - transmit pointer register holds head and tail
// - any debug bit set halts module traffic
// - any error register write resets link
// - error register holds three 8-bit counters
// - receive buffer window mapped at 04000-047FF
// - transmit buffer window mapped at 04800-04FFF

module gps_link_buffer_regs #(
	parameter PTR_W = 9
)(
	input wire sys_clk,
	input wire reset,
	input wire [15:0] addr,
	input wire [31:0] wr_data,
	input wire wr_strobe,
	input wire rd_strobe,
	output wire [31:0] rd_data,
	input wire link_rx_valid,
	input wire [31:0] link_rx_data,
	output wire link_rx_ready,
	output wire link_tx_valid,
	output wire [31:0] link_tx_data,
	input wire link_tx_ready,
	input wire pps_ok_pulse,
	input wire parity_err_pulse,
	input wire short_start_pulse,
	output wire link_enable,
	output wire link_reset
);

localparam DEPTH = 1 << PTR_W;

// buffer storage, plain flip-flops without reset
reg [31:0] rx_mem [0:DEPTH-1];
reg [31:0] tx_mem [0:DEPTH-1];

reg [PTR_W-1:0] rx_head_r;
reg [PTR_W-1:0] rx_tail_r;
reg [PTR_W-1:0] tx_head_r;
reg [PTR_W-1:0] tx_tail_r;
reg [`DEBUG_W-1:0] debug_r;
reg [31:0] tx_data_r;
reg tx_valid_r;
reg link_reset_r;
reg [31:0] rd_data_r;
reg [31:0] rd_data_nxt;

wire [PTR_W-1:0] rx_head_inc;
wire [PTR_W-1:0] tx_tail_inc;
wire [PTR_W-1:0] sw_idx;
wire [4:0] win_sel;
wire halted;
wire rx_full;
wire tx_empty;
wire rx_push;
wire tx_load;
wire err_write;
wire [`ERR_CNT_W-1:0] pps_ok_cnt;
wire [`ERR_CNT_W-1:0] parity_err_cnt;
wire [`ERR_CNT_W-1:0] short_start_cnt;
wire [31:0] rx_ptr_word;
wire [31:0] tx_ptr_word;
wire [31:0] err_word;

// address decode for the two data windows
assign win_sel = addr[`WIN_SEL_MSB:`WIN_SEL_LSB];
assign sw_idx = addr[`WORD_IDX_LSB+PTR_W-1:`WORD_IDX_LSB];

// debug bits override everything on the link side but the link reset pulse
assign halted = |debug_r;
assign link_enable = ~halted;

// ring arithmetic wraps naturally at the pointer width
assign rx_head_inc = rx_head_r + 1'b1;
assign tx_tail_inc = tx_tail_r + 1'b1;
// one slot stays free so a full ring never looks empty
assign rx_full = (rx_head_inc == rx_tail_r);
assign tx_empty = (tx_head_r == tx_tail_r);

// link handshakes; halted or resetting link sees no room
assign link_rx_ready = ~rx_full & ~halted & ~link_reset_r;
assign rx_push = link_rx_valid & link_rx_ready;
assign tx_load = ~tx_empty & ~halted & ~link_reset_r &
	(~tx_valid_r | link_tx_ready);

assign link_tx_valid = tx_valid_r;
assign link_tx_data = tx_data_r;
assign link_reset = link_reset_r;
assign rd_data = rd_data_r;

// any value written to the error register counts as a link reset
assign err_write = wr_strobe && (addr == `ERR_OFFSET);

// packed register images for read back
assign rx_ptr_word = ({{(32-PTR_W){1'b0}}, rx_head_r} << `HEAD_LSB) |
	({{(32-PTR_W){1'b0}}, rx_tail_r} << `TAIL_LSB);
assign tx_ptr_word = ({{(32-PTR_W){1'b0}}, tx_head_r} << `HEAD_LSB) |
	({{(32-PTR_W){1'b0}}, tx_tail_r} << `TAIL_LSB);
assign err_word = {pps_ok_cnt, parity_err_cnt, short_start_cnt,
	8'h00};

// error counters; cleared by the same write that resets the link
event_counter #(
	.W(`ERR_CNT_W)
) pps_ok_counter (
	.sys_clk(sys_clk),
	.reset(reset),
	.clear(err_write),
	.event_pulse(pps_ok_pulse & ~halted),
	.count(pps_ok_cnt)
);

event_counter #(
	.W(`ERR_CNT_W)
) parity_err_counter (
	.sys_clk(sys_clk),
	.reset(reset),
	.clear(err_write),
	.event_pulse(parity_err_pulse & ~halted),
	.count(parity_err_cnt)
);

event_counter #(
	.W(`ERR_CNT_W)
) short_start_counter (
	.sys_clk(sys_clk),
	.reset(reset),
	.clear(err_write),
	.event_pulse(short_start_pulse & ~halted),
	.count(short_start_cnt)
);

// receive storage: link fills it, software only reads
always @(posedge sys_clk)
begin
	if (rx_push)
		rx_mem[rx_head_r] <= link_rx_data;
end

// transmit storage: software fills it through its window
always @(posedge sys_clk)
begin
	if (wr_strobe && win_sel == `TX_WIN_SEL)
		tx_mem[sw_idx] <= wr_data;
end

// receive head is owned by the device, tail by software
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
	begin
		rx_head_r <= `PTR_RESET;
		rx_tail_r <= `PTR_RESET;
	end
	else
	begin
		if (rx_push)
			rx_head_r <= rx_head_inc;
		if (wr_strobe && addr == `RX_PTR_OFFSET)
			rx_tail_r <= wr_data[`TAIL_LSB+PTR_W-1:`TAIL_LSB];
	end
end

// transmit head is owned by software, tail by the device
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
	begin
		tx_head_r <= `PTR_RESET;
		tx_tail_r <= `PTR_RESET;
	end
	else
	begin
		if (tx_load)
			tx_tail_r <= tx_tail_inc;
		if (wr_strobe && addr == `TX_PTR_OFFSET)
			tx_head_r <= wr_data[`HEAD_LSB+PTR_W-1:`HEAD_LSB];
	end
end

// one-word output stage toward the link; a word taken from the ring
// is dropped if the link is reset before it is accepted
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
	begin
		tx_valid_r <= 1'b0;
		tx_data_r <= 32'h00000000;
	end
	else if (link_reset_r)
	begin
		tx_valid_r <= 1'b0;
	end
	else if (tx_load)
	begin
		tx_valid_r <= 1'b1;
		tx_data_r <= tx_mem[tx_tail_r];
	end
	else if (link_tx_ready || halted)
	begin
		tx_valid_r <= 1'b0;
	end
end

// debug control, plain read/write
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
		debug_r <= `DEBUG_RESET;
	else if (wr_strobe && addr == `DEBUG_OFFSET)
		debug_r <= wr_data[`DEBUG_W-1:0];
end

// link reset is a one-cycle pulse after the error register write
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
		link_reset_r <= 1'b0;
	else
		link_reset_r <= err_write;
end

// read multiplexer; unmapped addresses read as zero
always @*
begin
	rd_data_nxt = 32'h00000000;
	case (win_sel)
		`RX_WIN_SEL:
			rd_data_nxt = rx_mem[sw_idx];
		`TX_WIN_SEL:
			rd_data_nxt = tx_mem[sw_idx];
		default:
		begin
			if (addr == `RX_PTR_OFFSET)
				rd_data_nxt = rx_ptr_word;
			else if (addr == `TX_PTR_OFFSET)
				rd_data_nxt = tx_ptr_word;
			else if (addr == `DEBUG_OFFSET)
				rd_data_nxt = {{(32-`DEBUG_W){1'b0}}, debug_r};
			else if (addr == `ERR_OFFSET)
				rd_data_nxt = err_word;
		end
	endcase
end

// read data stands only in the cycle after the strobe
always @(posedge sys_clk or posedge reset)
begin
	if (reset)
		rd_data_r <= 32'h00000000;
	else if (rd_strobe)
		rd_data_r <= rd_data_nxt;
	else
		rd_data_r <= 32'h00000000;
end

endmodule

// *** gps_link_buffer_regs_properties.sv ***
`timescale 1ns/1ps
module gps_link_buffer_regs_chk(
	input wire sys_clk,
	input wire reset,
	input wire [15:0] addr,
	input wire [31:0] wr_data,
	input wire wr_strobe,
	input wire rd_strobe,
	input wire [31:0] rd_data,
	input wire link_rx_ready,
	input wire link_tx_valid,
	input wire [31:0] link_tx_data,
	input wire link_tx_ready,
	input wire link_enable,
	input wire link_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// bus answers and link side effects, tied to their causes
	chk_rd_idle: assert property (!$past(rd_strobe) |-> rd_data == 32'h0)
		else $error("read data outside read slot");
	chk_err_rsvd: assert property ($past(rd_strobe) &&
		$past(addr) == 16'h320C |-> rd_data[7:0] == 8'h00)
		else $error("error register low byte not zero");
	chk_clr_pulse: assert property (wr_strobe && addr == 16'h320C |=>
		link_reset) else $error("no link reset after write");
	chk_pulse_cause: assert property (link_reset |->
		$past(wr_strobe) && $past(addr) == 16'h320C)
		else $error("link reset without cause");
	chk_halt_set: assert property (wr_strobe && addr == 16'h3208 &&
		wr_data[7:0] != 8'h00 |=> !link_enable)
		else $error("debug write did not halt");
	chk_halt_rx: assert property (!link_enable |-> !link_rx_ready)
		else $error("receive open while halted");
	chk_halt_tx: assert property (!link_enable |=> !link_tx_valid)
		else $error("transmit while halted");
	chk_tx_hold: assert property (link_tx_valid && !link_tx_ready &&
		link_enable && !link_reset |=> link_tx_valid &&
		$stable(link_tx_data)) else $error("transmit word not held");
endmodule
bind gps_link_buffer_regs gps_link_buffer_regs_chk u_chk(.sys_clk, .reset,
	.addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .link_rx_ready,
	.link_tx_valid, .link_tx_data, .link_tx_ready, .link_enable,
	.link_reset);

// *** gps_module_model.sv ***
`timescale 1ns/1ps
module gps_module_model(
	input wire sys_clk,
	input wire stall,
	input wire link_rx_ready,
	input wire link_tx_valid,
	input wire [31:0] link_tx_data,
	output logic link_rx_valid = 1'b0,
	output logic [31:0] link_rx_data = 32'h0,
	output wire link_tx_ready
);
	logic [31:0] got[$];
	logic r;
	// stalls only when the bench asks
	assign link_tx_ready = !stall;
	// keep every word the device hands over
	always @(posedge sys_clk)
		if (link_tx_valid && link_tx_ready)
			got.push_back(link_tx_data);
	// word held until ready seen high at an edge
	task send(input logic [31:0] w);
	begin
		link_rx_valid <= 1'b1;
		link_rx_data <= w;
		do
		begin
			@(negedge sys_clk) r = link_rx_ready;
			@(posedge sys_clk);
		end
		while (!r);
	end
	endtask
	// released data line shows garbage, not the last word
	task idle;
	begin
		link_rx_valid <= 1'b0;
		link_rx_data <= ~link_rx_data;
	end
	endtask
endmodule

// *** gps_link_buffer_regs_tb.sv ***
`timescale 1ns/1ps
module gps_link_buffer_regs_tb;
	logic sys_clk = 0, reset = 1, wr_strobe = 0, rd_strobe = 0, stall = 0;
	logic [15:0] addr = 16'h0;
	logic [31:0] wr_data = 32'h0, rd_data, link_tx_data, link_rx_data;
	logic [2:0] ev = 3'h0;
	logic link_rx_valid, link_rx_ready, link_tx_valid, link_tx_ready;
	logic link_enable, link_reset;
	int miscompares = 0, num_checks = 0;
	gps_link_buffer_regs #(.PTR_W(9)) u_dut(.sys_clk, .reset, .addr,
		.wr_data, .wr_strobe, .rd_strobe, .rd_data, .link_rx_valid,
		.link_rx_data, .link_rx_ready, .link_tx_valid, .link_tx_data,
		.link_tx_ready, .pps_ok_pulse(ev[2]), .parity_err_pulse(ev[1]),
		.short_start_pulse(ev[0]), .link_enable, .link_reset);
	gps_module_model u_gps(.sys_clk, .stall, .link_rx_ready, .link_tx_valid,
		.link_tx_data, .link_rx_valid, .link_rx_data, .link_tx_ready);
	initial
		forever #5 sys_clk = ~sys_clk;
	task chk(input string n, input logic [31:0] s, e);
	begin
		num_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
	begin
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge sys_clk);
		wr_strobe <= 1'b0;
	end
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
	begin
		@(posedge sys_clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge sys_clk);
		rd_strobe <= 1'b0;
		#1 chk("rd_data", rd_data, e);
	end
	endtask
	task stop_test;
	begin
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// hang guard, well past the some six hundred cycles needed
	initial
	begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(16'h3300, 32'h0);
		// offer the first word right on an edge, like every other input
		@(posedge sys_clk);
		u_gps.send(32'hA5A50001);
		u_gps.send(32'h5A5A0002);
		u_gps.idle();
		rd(16'h3200, 32'h00020000);
		wr(16'h4000, 32'h0);
		rd(16'h4000, 32'hA5A50001);
		rd(16'h4004, 32'h5A5A0002);
		wr(16'h3200, 32'h2);
		rd(16'h3200, 32'h00020002);
		@(posedge sys_clk) stall <= 1'b1;
		wr(16'h4800, 32'h11);
		wr(16'h4804, 32'h22);
		rd(16'h4804, 32'h22);
		wr(16'h3204, 32'h00020000);
		repeat (4) @(posedge sys_clk);
		chk("tx_data", link_tx_data, 32'h11);
		stall <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("tx_count", u_gps.got.size(), 32'h2);
		chk("tx_first", u_gps.got[0], 32'h11);
		chk("tx_word", u_gps.got[1], 32'h22);
		rd(16'h3204, 32'h00020002);
		// three, two and one events on the three counters
		for (int i = 0; i < 3; i++)
			@(posedge sys_clk) ev <= {1'b1, i < 2, i < 1};
		@(posedge sys_clk) ev <= 3'h0;
		rd(16'h320C, 32'h03020100);
		wr(16'h320C, 32'h0);
		// the pulse stands in the cycle after the write and shuts the link
		#1 chk("link_reset", link_reset, 32'h1);
		chk("rx_reset", link_rx_ready, 32'h0);
		rd(16'h320C, 32'h0);
		wr(16'h3208, 32'h1);
		#1 chk("enable", link_enable, 32'h0);
		// a word queued while halted must not reach the link until the debug bits clear
		wr(16'h4808, 32'h33);
		wr(16'h3204, 32'h00030000);
		repeat (3) @(posedge sys_clk);
		#1 chk("tx_halted", link_tx_valid, 32'h0);
		chk("rx_halted", link_rx_ready, 32'h0);
		rd(16'h3208, 32'h1);
		@(posedge sys_clk) ev <= 3'h4;
		@(posedge sys_clk) ev <= 3'h0;
		rd(16'h320C, 32'h0);
		wr(16'h3208, 32'h0);
		#1 chk("enable", link_enable, 32'h1);
		repeat (4) @(posedge sys_clk);
		chk("tx_resume", u_gps.got[2], 32'h33);
		// event in the same cycle as the clear: the event survives
		fork
			wr(16'h320C, 32'h0);
			begin
				@(posedge sys_clk) ev <= 3'h1;
				@(posedge sys_clk) ev <= 3'h0;
			end
		join
		rd(16'h320C, 32'h00000100);
		// fill the receive ring; one slot stays free
		@(posedge sys_clk);
		repeat (511) u_gps.send(32'h0);
		u_gps.idle();
		@(negedge sys_clk) chk("rx_full", link_rx_ready, 32'h0);
		rd(16'h3200, 32'h00010002);
		stop_test();
	end
endmodule
